// >>> pmsc_pkg.sv
package pmsc_pkg;

    // ==========================================================
    // Register map (word offsets as byte addresses)
    // ==========================================================
    localparam logic [3:0] PMSC_OFS_ONE    = 4'h0;
    localparam logic [3:0] PMSC_OFS_TWO    = 4'h4;
    localparam logic [3:0] PMSC_OFS_STATUS = 4'h8;
    localparam logic [3:0] PMSC_OFS_MASK   = 4'hc;

    // ==========================================================
    // First register fields
    // ==========================================================
    localparam int PMSC_B1_DET_FLAG     = 7;
    localparam int PMSC_B1_DET_ACK      = 6;
    localparam int PMSC_B1_DET_ENABLE   = 5;
    localparam int PMSC_B1_DET_STOP_EN  = 4;
    localparam int PMSC_B1_BANDGAP_EN   = 3;
    localparam int PMSC_B1_DET_RESET_EN = 2;
    localparam int PMSC_B1_RESERVED     = 1;
    localparam int PMSC_B1_DET_INT_EN   = 0;

    // ==========================================================
    // Second register fields
    // ==========================================================
    localparam int PMSC_B2_WARN_FLAG    = 7;
    localparam int PMSC_B2_WARN_ACK     = 6;
    localparam int PMSC_B2_DET_TRIP     = 5;
    localparam int PMSC_B2_WARN_TRIP    = 4;
    localparam int PMSC_B2_PPD_FLAG     = 3;
    localparam int PMSC_B2_PPD_ACK      = 2;
    localparam int PMSC_B2_STOP_DEPTH   = 0;

    // ==========================================================
    // Interrupt status bits
    // ==========================================================
    localparam int PMSC_IRQ_DETECT = 0;
    localparam int PMSC_IRQ_WARN   = 1;
    localparam int PMSC_IRQ_PPD    = 2;
    localparam int PMSC_IRQ_W      = 3;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [7:0] PMSC_RST_ONE  = 8'h1c;
    localparam logic [7:0] PMSC_RST_TWO  = 8'h00;
    localparam logic [2:0] PMSC_RST_MASK = 3'h0;

endpackage : pmsc_pkg

// >>> pmsc_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser for asynchronous level inputs.
module pmsc_sync
#(
    parameter int W = 1
)
(
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } pmsc_sync_t;

    pmsc_sync_t sync_reg;
    pmsc_sync_t sync_next;

    always_comb
    begin
        sync_next        = sync_reg;
        sync_next.stage1 = async_in;
        sync_next.stage2 = sync_reg.stage1;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync_reg <= '0;
        end
        else
        begin
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg.stage2;

endmodule : pmsc_sync

// >>> pmsc_regs.sv
`timescale 1ns/1ps

module pmsc_regs
    import pmsc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        low_voltage_detect_in,
    input  wire logic        low_voltage_warning_in,
    input  wire logic        stop_request,
    input  wire logic        stop2_recovery,
    output logic             low_voltage_detect_enable,
    output logic             detector_active,
    output logic             detect_trip_select,
    output logic             warning_trip_select,
    output logic             stop_depth_select,
    output logic             deep_stop_blocked,
    output logic             bandgap_enable,
    output logic             detect_reset_enable,
    output logic             irq
);
    import pmsc_pkg::*;

    // ==========================================================
    // Reset release and input synchronisation
    // ==========================================================
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_sync_reg <= 2'h0;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_reg[1];

    logic [3:0] pins_s;

    pmsc_sync #(
        .W (4)
    ) u_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in ({stop2_recovery, stop_request,
                    low_voltage_warning_in, low_voltage_detect_in}),
        .sync_out (pins_s)
    );

    logic det_s;
    logic warn_s;
    logic stop_s;
    logic ppd_s;

    assign det_s  = pins_s[0];
    assign warn_s = pins_s[1];
    assign stop_s = pins_s[2];
    assign ppd_s  = pins_s[3];

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic                det_flag;
        logic                det_enable;
        logic                det_stop_en;
        logic                bandgap_en;
        logic                det_reset_en;
        logic                det_int_en;
        logic                warn_flag;
        logic                det_trip;
        logic                warn_trip;
        logic                ppd_flag;
        logic                stop_depth;
        logic                stop_depth_locked;
        logic                in_stop;
        logic                ppd_prev;
        logic [PMSC_IRQ_W-1:0] status;
        logic [PMSC_IRQ_W-1:0] mask;
        logic                ack;
        logic [31:0]         rdata;
        logic                det_active;
        logic                deep_block;
        logic                irq;
    } pmsc_state_t;

    pmsc_state_t st_reg;
    pmsc_state_t st_next;

    // ==========================================================
    // Address decode
    // ==========================================================
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    logic       wr_lo;
    logic [7:0] wd;
    logic [7:0] rd_one;
    logic [7:0] rd_two;
    logic [PMSC_IRQ_W-1:0] ev;

    always_comb
    begin
        st_next = st_reg;
        wd      = avs_writedata[7:0];
        wr_lo   = avs_write && avs_byteenable[0] && st_reg.ack;
        ev      = '0;
        rd_one  = 8'h00;
        rd_two  = 8'h00;

        // ======================================================
        // Detector gating and hardware events
        // ======================================================
        // The stop level passes one more register before it gates the
        // detector, a one-cycle lag that is harmless against pin timescales.
        // detector gating: events only counted while enabled.
        // stop gating: detector off in stop unless stop-enable.
        st_next.in_stop    = stop_s;
        st_next.det_active = st_reg.det_enable &&
                             (!st_reg.in_stop || st_reg.det_stop_en);
        // deep stop blocked when both enables set.
        st_next.deep_block = st_reg.det_enable && st_reg.det_stop_en;

        if (det_s && st_reg.det_active && !st_reg.det_flag)
        begin
            ev[PMSC_IRQ_DETECT] = 1'b1;
        end
        if (warn_s && !st_reg.warn_flag)
        begin
            ev[PMSC_IRQ_WARN] = 1'b1;
        end
        // Both synchroniser and edge register reset to the idle low level
        // of the wakeup pin, so no false edge follows reset.
        st_next.ppd_prev = ppd_s;
        if (ppd_s && !st_reg.ppd_prev)
        begin
            ev[PMSC_IRQ_PPD] = 1'b1;
        end

        // ======================================================
        // Bus handshake
        // ======================================================
        // Every access has exactly one wait cycle. Read data are taken in
        // the request cycle and a write lands at the edge that ends the
        // answer cycle, the edge at which the master sees waitrequest low.
        // The fixed cost of one cycle buys registered outputs on the bus.
        // Acknowledge one cycle after the request is seen; one wait cycle.
        st_next.ack = (avs_read || avs_write) && !st_reg.ack;

        // ======================================================
        // Software writes
        // ======================================================
        // A write without lane zero is still answered but changes nothing.
        // The detect interrupt enable is only stored; whether the detect
        // event reaches the interrupt output is decided by the mask register.
        if (wr_lo && hit(avs_address, PMSC_OFS_ONE))
        begin
            if (wd[PMSC_B1_DET_ACK])
            begin
                st_next.det_flag = 1'b0;
            end
            st_next.det_enable   = wd[PMSC_B1_DET_ENABLE];
            st_next.det_stop_en  = wd[PMSC_B1_DET_STOP_EN];
            st_next.bandgap_en   = wd[PMSC_B1_BANDGAP_EN];
            st_next.det_reset_en = wd[PMSC_B1_DET_RESET_EN];
            st_next.det_int_en   = wd[PMSC_B1_DET_INT_EN];
        end

        if (wr_lo && hit(avs_address, PMSC_OFS_TWO))
        begin
            // The pin is tested here as well as by the set further down, so
            // an acknowledge cannot clear the flag while the warning stands.
            // warning ack only without present warning.
            // ack is a strobe, not stored.
            if (wd[PMSC_B2_WARN_ACK] && !warn_s)
            begin
                st_next.warn_flag = 1'b0;
            end
            if (wd[PMSC_B2_PPD_ACK])
            begin
                st_next.ppd_flag = 1'b0;
            end
            st_next.det_trip  = wd[PMSC_B2_DET_TRIP];
            st_next.warn_trip = wd[PMSC_B2_WARN_TRIP];
            // Any write to this register with lane zero locks the depth
            // select, even one that writes its reset value.
            // write-once lock.
            if (!st_reg.stop_depth_locked)
            begin
                st_next.stop_depth        = wd[PMSC_B2_STOP_DEPTH];
                st_next.stop_depth_locked = 1'b1;
            end
        end

        // ======================================================
        // Interrupt status and mask
        // ======================================================
        if (wr_lo && hit(avs_address, PMSC_OFS_STATUS))
        begin
            st_next.status = st_reg.status & ~wd[PMSC_IRQ_W-1:0];
        end
        if (wr_lo && hit(avs_address, PMSC_OFS_MASK))
        begin
            st_next.mask = wd[PMSC_IRQ_W-1:0];
        end

        // ======================================================
        // Hardware sets
        // ======================================================
        // Hardware events are applied last so a set beats a same-cycle clear.
        // detect flag set while enabled.
        if (ev[PMSC_IRQ_DETECT])
        begin
            st_next.det_flag = 1'b1;
        end
        if (warn_s)
        begin
            st_next.warn_flag = 1'b1;
        end
        if (ev[PMSC_IRQ_PPD])
        begin
            st_next.ppd_flag = 1'b1;
        end
        st_next.status = st_next.status | ev;

        // ======================================================
        // Read path
        // ======================================================
        // detect flag read valid only while enabled.
        rd_one[PMSC_B1_DET_FLAG]     = st_reg.det_flag && st_reg.det_enable;
        rd_one[PMSC_B1_DET_ENABLE]   = st_reg.det_enable;
        rd_one[PMSC_B1_DET_STOP_EN]  = st_reg.det_stop_en;
        rd_one[PMSC_B1_BANDGAP_EN]   = st_reg.bandgap_en;
        rd_one[PMSC_B1_DET_RESET_EN] = st_reg.det_reset_en;
        rd_one[PMSC_B1_DET_INT_EN]   = st_reg.det_int_en;
        rd_two[PMSC_B2_WARN_FLAG]    = st_reg.warn_flag;
        rd_two[PMSC_B2_DET_TRIP]     = st_reg.det_trip;
        rd_two[PMSC_B2_WARN_TRIP]    = st_reg.warn_trip;
        rd_two[PMSC_B2_PPD_FLAG]     = st_reg.ppd_flag;
        rd_two[PMSC_B2_STOP_DEPTH]   = st_reg.stop_depth;

        st_next.rdata = 32'h0000_0000;
        if (avs_read && !st_reg.ack)
        begin
            case (avs_address)
                PMSC_OFS_ONE:    st_next.rdata = {24'h000000, rd_one};
                PMSC_OFS_TWO:    st_next.rdata = {24'h000000, rd_two};
                PMSC_OFS_STATUS: st_next.rdata = {29'h0, st_reg.status};
                PMSC_OFS_MASK:   st_next.rdata = {29'h0, st_reg.mask};
                default:         st_next.rdata = 32'h0000_0000;
            endcase
        end

        // ======================================================
        // Interrupt output
        // ======================================================
        // The output trails the status by a cycle so that it leaves the
        // block straight from a flip-flop.
        st_next.irq = |(st_reg.status & st_reg.mask);
    end

    // ==========================================================
    // Registers
    // ==========================================================
    // The reset branch loads constants only. Bits that are not named here
    // come out of reset at zero, which covers every flag, the depth lock
    // and the bus answer.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg              <= '0;
            st_reg.det_enable   <= PMSC_RST_ONE[PMSC_B1_DET_ENABLE];
            st_reg.det_stop_en  <= PMSC_RST_ONE[PMSC_B1_DET_STOP_EN];
            st_reg.bandgap_en   <= PMSC_RST_ONE[PMSC_B1_BANDGAP_EN];
            st_reg.det_reset_en <= PMSC_RST_ONE[PMSC_B1_DET_RESET_EN];
            st_reg.det_int_en   <= PMSC_RST_ONE[PMSC_B1_DET_INT_EN];
            st_reg.det_trip     <= PMSC_RST_TWO[PMSC_B2_DET_TRIP];
            st_reg.warn_trip    <= PMSC_RST_TWO[PMSC_B2_WARN_TRIP];
            st_reg.stop_depth   <= PMSC_RST_TWO[PMSC_B2_STOP_DEPTH];
            st_reg.mask         <= PMSC_RST_MASK;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Waitrequest is low only in the answer cycle.
    assign avs_waitrequest           = !st_reg.ack;
    assign avs_readdata              = st_reg.rdata;
    assign low_voltage_detect_enable = st_reg.det_enable;
    assign detector_active           = st_reg.det_active;
    assign detect_trip_select        = st_reg.det_trip;
    assign warning_trip_select       = st_reg.warn_trip;
    assign stop_depth_select         = st_reg.stop_depth;
    assign deep_stop_blocked         = st_reg.deep_block;
    assign bandgap_enable            = st_reg.bandgap_en;
    assign detect_reset_enable       = st_reg.det_reset_en;
    assign irq                       = st_reg.irq;

endmodule : pmsc_regs

// >>> pmsc_regs_checker.sv
`timescale 1ns/1ps

// ==========================================================
// Port-level checks on the power management register block
// ==========================================================
module pmsc_regs_checker
(
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        low_voltage_warning_in,
    input wire logic        low_voltage_detect_enable,
    input wire logic        detector_active,
    input wire logic        deep_stop_blocked,
    input wire logic        detect_trip_select,
    input wire logic        stop_depth_select,
    input wire logic        irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    logic rd_ans;
    assign rd_ans = avs_read && !avs_waitrequest;

    property p_wait_one;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("request not answered in time");

    property p_stand;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_stand: assert property (p_stand) else $error("answer held too long");

    property p_det_ack_zero;
        rd_ans && avs_address == 4'h0 |-> !avs_readdata[6] && !avs_readdata[1];
    endproperty
    a_det_ack_zero: assert property (p_det_ack_zero) else $error("ack bit read as one");

    property p_det_gate;
        rd_ans && avs_address == 4'h0 && !low_voltage_detect_enable |-> !avs_readdata[7];
    endproperty
    a_det_gate: assert property (p_det_gate) else $error("detect flag shown while off");

    property p_ack_strobe;
        rd_ans && avs_address == 4'h4 |-> avs_readdata[31:8] == 24'h0
            && !avs_readdata[6] && !avs_readdata[2];
    endproperty
    a_ack_strobe: assert property (p_ack_strobe) else $error("strobe bits read as one");

    property p_trip;
        rd_ans && avs_address == 4'h4 |-> avs_readdata[5] == detect_trip_select
            && avs_readdata[0] == stop_depth_select;
    endproperty
    a_trip: assert property (p_trip) else $error("select outputs differ from register");

    property p_warn_sticky;
        low_voltage_warning_in[*8] ##0 (rd_ans && avs_address == 4'h4) |-> avs_readdata[7];
    endproperty
    a_warn_sticky: assert property (p_warn_sticky) else $error("warning flag lost");

    property p_active;
        !low_voltage_detect_enable[*2] |-> !detector_active && !deep_stop_blocked;
    endproperty
    a_active: assert property (p_active) else $error("detector active while off");

    property p_irq_mask;
        avs_write && !avs_waitrequest && avs_address == 4'hc && avs_byteenable[0]
            && avs_writedata[2:0] == 3'h0 |-> ##2 !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt not masked");
endmodule : pmsc_regs_checker

bind pmsc_regs pmsc_regs_checker i_chk (.mclk, .reset_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .low_voltage_warning_in, .low_voltage_detect_enable, .detector_active,
    .deep_stop_blocked, .detect_trip_select, .stop_depth_select, .irq);

// >>> pmsc_regs_bench.sv
`timescale 1ns/1ps

module pmsc_regs_bench;
    import pmsc_pkg::*;
    typedef struct packed {logic w; logic [3:0] a; logic [7:0] d;} pmsc_row_t;
    logic        mclk, reset_n, avs_read, avs_write, avs_waitrequest, irq;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic        low_voltage_detect_in, low_voltage_warning_in, stop_request, stop2_recovery;
    logic        low_voltage_detect_enable, detector_active, detect_trip_select;
    logic        warning_trip_select, stop_depth_select, deep_stop_blocked;
    logic        bandgap_enable, detect_reset_enable;
    int          err_total, tests_run, cyc;
    pmsc_row_t   rows [12];

    pmsc_regs i_dut
    (
        .mclk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .low_voltage_detect_in,
        .low_voltage_warning_in, .stop_request, .stop2_recovery,
        .low_voltage_detect_enable, .detector_active, .detect_trip_select,
        .warning_trip_select, .stop_depth_select, .deep_stop_blocked,
        .bandgap_enable, .detect_reset_enable, .irq
    );

    // ==========================================================
    // Bus and check tasks
    // ==========================================================
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, s);
            err_total++;
        end
    endtask : chk

    // Waits one edge first so no request signal is assigned twice in a step.
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                       input logic [3:0] be);
        @(posedge mclk);
        avs_address    <= a;
        avs_writedata  <= {24'h0, d};
        avs_byteenable <= be;
        avs_write      <= w;
        avs_read       <= !w;
        do
            @(posedge mclk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'h0;
        avs_write <= 1'h0;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'h1, a, d, 4'h1);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        bus(1'h0, a, 8'h00, 4'h1);
        chk("readdata", q, {24'h0, e});
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    task automatic end_of_test();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    initial
    begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end

    // The whole run needs well under a thousand cycles.
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_total++;
            end_of_test();
        end
    end

    // ==========================================================
    // Sequence
    // ==========================================================
    initial
    begin
        {reset_n, avs_read, avs_write, low_voltage_detect_in, stop_request} = 5'h0;
        {low_voltage_warning_in, stop2_recovery} = 2'h0;
        {avs_address, avs_writedata, avs_byteenable} = 40'h0;
        {err_total, tests_run, cyc} = {32'h0, 32'h0, 32'h0};
        rows = '{'{1'h0, 4'h0, 8'h1c}, '{1'h0, 4'h4, 8'h00}, '{1'h0, 4'h8, 8'h00},
                 '{1'h0, 4'hc, 8'h00}, '{1'h1, 4'h2, 8'hff}, '{1'h0, 4'h2, 8'h00},
                 '{1'h1, 4'h4, 8'h31}, '{1'h0, 4'h4, 8'h31}, '{1'h1, 4'h4, 8'h00},
                 '{1'h0, 4'h4, 8'h01}, '{1'h1, 4'h0, 8'h79}, '{1'h0, 4'h0, 8'h39}};
        tick(16);
        reset_n <= 1'h1;
        tick(3);
        chk("reset_outputs", {low_voltage_detect_enable, bandgap_enable,
            detect_reset_enable, irq, avs_waitrequest}, 32'h0d);
        foreach (rows[i])
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            else
                rd(rows[i].a, rows[i].d);
        chk("controls", {detect_trip_select, warning_trip_select, stop_depth_select,
            bandgap_enable, detect_reset_enable, detector_active, deep_stop_blocked},
            32'h1b);
        wr(4'hc, 8'h07);
        low_voltage_detect_in <= 1'h1;
        tick(8);
        rd(4'h0, 8'hb9);
        rd(4'h8, 8'h01);
        chk("irq", irq, 32'h1);
        low_voltage_detect_in <= 1'h0;
        tick(8);
        wr(4'h0, 8'h79);
        rd(4'h0, 8'h39);
        wr(4'h8, 8'h07);
        rd(4'h8, 8'h00);
        chk("irq", irq, 32'h0);
        wr(4'h0, 8'h19);
        low_voltage_detect_in <= 1'h1;
        tick(8);
        rd(4'h0, 8'h19);
        chk("detector", {detector_active, deep_stop_blocked}, 32'h0);
        low_voltage_detect_in <= 1'h0;
        tick(4);
        wr(4'h8, 8'h07);
        low_voltage_warning_in <= 1'h1;
        tick(8);
        rd(4'h4, 8'h81);
        wr(4'h4, 8'h41);
        rd(4'h4, 8'h81);
        chk("irq", irq, 32'h1);
        wr(4'hc, 8'h00);
        tick(3);
        chk("irq", irq, 32'h0);
        low_voltage_warning_in <= 1'h0;
        tick(8);
        rd(4'h4, 8'h81);
        wr(4'h4, 8'h41);
        rd(4'h4, 8'h01);
        stop2_recovery <= 1'h1;
        tick(8);
        rd(4'h4, 8'h09);
        stop2_recovery <= 1'h0;
        wr(4'h4, 8'h05);
        rd(4'h4, 8'h01);
        bus(1'h1, 4'h4, 8'h30, 4'h0);
        rd(4'h4, 8'h01);
        wr(4'h0, 8'h29);
        stop_request <= 1'h1;
        tick(8);
        chk("stop_off", {detector_active, deep_stop_blocked}, 32'h0);
        wr(4'h0, 8'h39);
        tick(4);
        chk("stop_on", {detector_active, deep_stop_blocked}, 32'h3);
        stop_request <= 1'h0;
        reset_n <= 1'h0;
        tick(2);
        reset_n <= 1'h1;
        tick(3);
        rd(4'h0, 8'h1c);
        wr(4'h4, 8'h00);
        wr(4'h4, 8'h01);
        rd(4'h4, 8'h00);
        end_of_test();
    end
endmodule : pmsc_regs_bench
